// *** core/ee_spi_slave.sv ***
// Contract
// - output bit changes on falling clock edge
// - input bits captured on rising clock edge
// - chip select high floats output
// - deselected means standby unless write running
// - chip select low selects, active power
// - ignore traffic until first select fall
// - pause holds bit position, stays selected
// - pause floats output, ignores clock, data
// - write protect freezes protect size bits
// - array holds 131072 eight-bit bytes
// - all bytes shifted most significant first
// - modes 0 and 3 only supported
// - pause edges only while clock low
// - deselect in pause resets interface logic
`timescale 1ns/10ps
`default_nettype none
module ee_spi_slave #(
    parameter int P_WRITE_CYCLES = ee_pkg::WRITE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    input  wire logic i_hold_n,
    input  wire logic i_wp_n,
    output logic      o_miso,
    output logic      o_miso_oe,
    output logic      o_active,
    output logic      o_write_busy
);
    import ee_pkg::*;

    ee_ctl_if ctl_if ();

    // system-clock side: arming, power mode, write timer
    ee_pwr_ctl #(
        .P_WRITE_CYCLES (P_WRITE_CYCLES)
    ) u_pwr (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_cs_n   (i_cs_n),
        .ctl      (ctl_if.ctl),
        .o_active (o_active),
        .o_busy   (o_write_busy)
    );

    // status byte assembly
    function automatic logic [7:0] status_byte(input logic wip, input logic wel,
                                               input logic [1:0] prot);
        logic [7:0] s;
        s           = 8'h00;
        s[ST_WIP]   = wip;
        s[ST_WEL]   = wel;
        s[ST_PS_LO] = prot[0];
        s[ST_PS_HI] = prot[1];
        return s;
    endfunction

    logic [7:0]        mem [MEM_BYTES];

    // frame state, cleared whenever chip select is high
    ee_phase_t         phase_q, phase_d;
    logic [2:0]        bit_cnt_q, bit_cnt_d;   // bits taken in this byte
    logic [6:0]        shift_q, shift_d;       // bits before the last one
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [1:0]        abyte_q, abyte_d;       // address bytes received
    logic              is_rd_q, is_rd_d;       // read versus write command
    logic [7:0]        rd_byte_q, rd_byte_d;   // byte being returned
    logic              tx_en_q, tx_en_d;       // returning data now

    // persistent serial-clock state
    logic              wel_q, wel_d;           // write enable latch
    logic [1:0]        prot_q, prot_d;         // protect size selection
    logic              wr_tgl_q, wr_tgl_d;
    logic [1:0]        armed_s_q;              // synchroniser for armed
    logic [1:0]        busy_s_q;               // synchroniser for busy

    // falling-edge output state
    logic              miso_q, miso_d;
    logic              oe_q, oe_d;

    logic [7:0]        rx_byte;
    logic              byte_done;
    logic              mem_we;
    logic              cmd_done;

    assign rx_byte   = {shift_q, i_mosi};
    // rising edges while paused are ignored; pause only moves with clock low
    assign byte_done = i_hold_n & (bit_cnt_q == 3'h7);
    assign cmd_done  = byte_done & (phase_q == PH_CMD) & armed_s_q[1];
    assign mem_we    = byte_done & (phase_q == PH_WRITE);

    // next frame state from the bit on the input line
    always_comb begin
        phase_d   = phase_q;
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        addr_d    = addr_q;
        abyte_d   = abyte_q;
        is_rd_d   = is_rd_q;
        rd_byte_d = rd_byte_q;
        tx_en_d   = tx_en_q;
        if (i_hold_n) begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            shift_d   = {shift_q[5:0], i_mosi};
        end
        if (byte_done) begin
            case (phase_q)
                PH_CMD: begin
                    phase_d = PH_IDLE;                     // unknown or unarmed
                    if (armed_s_q[1]) begin
                        if (rx_byte == OP_RDSR) begin
                            phase_d   = PH_RDSR;
                            rd_byte_d = status_byte(busy_s_q[1], wel_q, prot_q);
                            tx_en_d   = 1'b1;
                        end else if (busy_s_q[1]) begin
                            phase_d = PH_IDLE;             // busy: status only
                        end else if (rx_byte == OP_READ) begin
                            phase_d = PH_ADDR;
                            is_rd_d = 1'b1;
                        end else if (rx_byte == OP_WRITE && wel_q) begin
                            phase_d = PH_ADDR;
                            is_rd_d = 1'b0;
                        end else if (rx_byte == OP_WRSR && wel_q) begin
                            phase_d = PH_WRSR;
                        end
                    end
                end
                PH_ADDR: begin
                    addr_d  = ADDR_W'({addr_q, rx_byte});
                    abyte_d = abyte_q + 2'h1;
                    if (abyte_q == 2'(ADDR_BYTES - 1)) begin
                        if (is_rd_q) begin
                            phase_d   = PH_READ;
                            rd_byte_d = mem[ADDR_W'({addr_q, rx_byte})];
                            tx_en_d   = 1'b1;
                        end else begin
                            phase_d = PH_WRITE;
                        end
                    end
                end
                PH_READ: begin
                    addr_d    = addr_q + 1'b1;             // wraps at top
                    rd_byte_d = mem[addr_q + 1'b1];
                end
                PH_WRITE: begin
                    // stay within the page
                    addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 1'b1;
                end
                PH_RDSR: begin
                    rd_byte_d = status_byte(busy_s_q[1], wel_q, prot_q);
                end
                PH_WRSR: begin
                    phase_d = PH_IDLE;
                end
                default: begin
                    phase_d = PH_IDLE;
                end
            endcase
        end
    end

    // chip select high clears the frame, mid-pause too
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            phase_q   <= PH_CMD;
            bit_cnt_q <= 3'h0;
            shift_q   <= 7'h00;
            addr_q    <= '0;
            abyte_q   <= 2'h0;
            is_rd_q   <= 1'b0;
            rd_byte_q <= 8'h00;
            tx_en_q   <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            addr_q    <= addr_d;
            abyte_q   <= abyte_d;
            is_rd_q   <= is_rd_d;
            rd_byte_q <= rd_byte_d;
            tx_en_q   <= tx_en_d;
        end
    end

    // next persistent state: latch, protect size, write toggle
    always_comb begin
        wel_d    = wel_q;
        prot_d   = prot_q;
        wr_tgl_d = wr_tgl_q;
        if (!armed_s_q[1]) begin
            wel_d    = 1'b0;                               // power-up state
            prot_d   = PROT_RST;
            wr_tgl_d = 1'b0;                               // matches control side reset
        end else if (cmd_done && rx_byte == OP_WREN && !busy_s_q[1]) begin
            wel_d = 1'b1;
        end else if (cmd_done && rx_byte == OP_WRDI && !busy_s_q[1]) begin
            wel_d = 1'b0;
        end else if (mem_we) begin
            wel_d    = 1'b0;
            wr_tgl_d = ~wr_tgl_q;
        end else if (byte_done && phase_q == PH_WRSR) begin
            wel_d    = 1'b0;
            wr_tgl_d = ~wr_tgl_q;
            // low protect pin freezes the size, pin held steady by master
            if (i_wp_n) begin
                prot_d = {rx_byte[ST_PS_HI], rx_byte[ST_PS_LO]};
            end
        end
    end

    // persistent registers survive deselection
    always_ff @(posedge i_sck) begin
        wel_q     <= wel_d;
        prot_q    <= prot_d;
        wr_tgl_q  <= wr_tgl_d;
        armed_s_q <= {armed_s_q[0], ctl_if.armed};
        busy_s_q  <= {busy_s_q[0], ctl_if.busy};
    end

    assign ctl_if.wr_tgl = wr_tgl_q;

    // array write at end of each data byte
    always_ff @(posedge i_sck) begin
        if (mem_we && !i_cs_n) begin
            mem[addr_q] <= rx_byte;
        end
    end

    // next output bit, msb first, counted by received bits
    always_comb begin
        oe_d   = tx_en_q;
        miso_d = rd_byte_q[~bit_cnt_q];
    end

    // falling edge drives data; pause release restores the held bit
    always_ff @(negedge i_sck or posedge i_cs_n or negedge i_hold_n or posedge i_hold_n) begin
        if (i_cs_n || !i_hold_n) begin
            oe_q   <= 1'b0;
            miso_q <= 1'b0;
        end else begin
            oe_q   <= oe_d;
            miso_q <= miso_d;
        end
    end

    assign o_miso    = miso_q;
    assign o_miso_oe = oe_q;
endmodule
`default_nettype wire

// *** pkg/ee_pkg.sv ***
package ee_pkg;
    // storage geometry
    localparam int ADDR_W     = 17;          // byte address width
    localparam int MEM_BYTES  = 131072;      // byte locations in the array
    localparam int PAGE_W     = 8;           // in-page address bits
    localparam int ADDR_BYTES = 3;           // address bytes after a command
    // command codes
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WREN  = 8'h06;
    // status byte field positions
    localparam int ST_WIP   = 0;             // write in progress
    localparam int ST_WEL   = 1;             // write enable latch
    localparam int ST_PS_LO = 2;             // protect_size_sel_lo
    localparam int ST_PS_HI = 3;             // protect_size_sel_hi
    // reset values
    localparam logic [1:0] PROT_RST   = 2'h0; // protect size after power-up
    localparam logic [1:0] CS_SYNC_RST = 2'h0; // chip select seen low: reset makes up no fall
    // timing
    localparam int CLK_PERIOD_NS = 20;       // system clock period
    localparam int WRITE_TIME_NS = 5000000;  // longest internal write time
    localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS; // rounds down
    localparam int WR_CNT_W      = 18;       // write timer width
    // serial sequencer phases
    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_READ, PH_WRITE, PH_WRSR, PH_RDSR, PH_IDLE
    } ee_phase_t;
endpackage

// *** pkg/ee_ctl_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// crossing signals between system-clock control and serial-clock logic
interface ee_ctl_if;
    logic armed;   // first chip select fall seen (system clock level)
    logic busy;    // internal write cycle running (system clock level)
    logic wr_tgl;  // toggles once per committed write byte (serial clock)
    modport ctl  (output armed, output busy, input wr_tgl);
    modport link (input armed, input busy, output wr_tgl);
endinterface
`default_nettype wire

// *** core/ee_pwr_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
module ee_pwr_ctl #(
    parameter int P_WRITE_CYCLES = ee_pkg::WRITE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_cs_n,
    ee_ctl_if.ctl     ctl,
    output logic      o_active,
    output logic      o_busy
);
    import ee_pkg::*;

    logic [1:0]          cs_sync_q, cs_sync_d;   // chip select synchroniser
    logic                cs_prev_q, cs_prev_d;   // for fall detection
    logic [1:0]          tg_sync_q, tg_sync_d;   // write toggle synchroniser
    logic                tg_prev_q, tg_prev_d;
    logic                armed_q, armed_d;       // first fall seen
    logic                pend_q, pend_d;         // write waiting for deselect
    logic                busy_q, busy_d;         // write cycle timer running
    logic [WR_CNT_W-1:0] cnt_q, cnt_d;
    logic                active_q, active_d;     // active power mode
    logic                cs_fall, tg_ev, start;

    // next state of arming, write timer and power mode
    always_comb begin
        cs_sync_d = {cs_sync_q[0], i_cs_n};
        tg_sync_d = {tg_sync_q[0], ctl.wr_tgl};
        cs_prev_d = cs_sync_q[1];
        tg_prev_d = tg_sync_q[1];
        cs_fall   = cs_prev_q & ~cs_sync_q[1];
        tg_ev     = tg_sync_q[1] ^ tg_prev_q;
        armed_d   = armed_q | cs_fall;
        start     = pend_q & cs_sync_q[1] & ~busy_q;   // write launches on deselect
        // new byte wins over the launch clear
        if (tg_ev) begin
            pend_d = 1'b1;
        end else if (start) begin
            pend_d = 1'b0;
        end else begin
            pend_d = pend_q;
        end
        busy_d = busy_q;
        cnt_d  = cnt_q;
        if (start) begin
            busy_d = 1'b1;
            cnt_d  = WR_CNT_W'(P_WRITE_CYCLES - 1);
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        // selected after the first fall means active; deselected stays active while writing
        // launch counts too, so deselect into a write shows no standby gap
        active_d = (armed_q & ~cs_sync_q[1]) | busy_q | start;
    end

    // registers of the control group
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_sync_q <= CS_SYNC_RST;
            cs_prev_q <= CS_SYNC_RST[1];
            tg_sync_q <= 2'h0;
            tg_prev_q <= 1'b0;
            armed_q   <= 1'b0;
            pend_q    <= 1'b0;
            busy_q    <= 1'b0;
            cnt_q     <= '0;
            active_q  <= 1'b0;
        end else begin
            cs_sync_q <= cs_sync_d;
            cs_prev_q <= cs_prev_d;
            tg_sync_q <= tg_sync_d;
            tg_prev_q <= tg_prev_d;
            armed_q   <= armed_d;
            pend_q    <= pend_d;
            busy_q    <= busy_d;
            cnt_q     <= cnt_d;
            active_q  <= active_d;
        end
    end

    assign ctl.armed = armed_q;
    assign ctl.busy  = busy_q;
    assign o_active  = active_q;
    assign o_busy    = busy_q;
endmodule
`default_nettype wire

// *** core/ee_dummy_none.sv ***
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** test/ee_spi_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module ee_spi_mon #(
    parameter int P_WRITE_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic o_active,
    input wire logic o_write_busy
);
    int   cnt_q, cnt_d;    // cycles of the running write
    logic cs_q, cs_d;      // chip select one clock ago
    logic seen_q, seen_d;  // a chip select fall seen
    // next values of helper state
    always_comb begin
        cs_d   = i_cs_n;
        seen_d = seen_q | (cs_q & ~i_cs_n);
        cnt_d  = o_write_busy ? cnt_q + 1 : 0;
    end
    // helper registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_q   <= 1'b0;
            seen_q <= 1'b0;
            cnt_q  <= 0;
        end else begin
            cs_q   <= cs_d;
            seen_q <= seen_d;
            cnt_q  <= cnt_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    cs_float_a: assert property (i_cs_n && $past(i_cs_n) |-> !o_miso_oe)
        else $error("output driven while deselected");
    hold_float_a: assert property (!i_hold_n && $past(!i_hold_n) |-> !o_miso_oe)
        else $error("output driven during pause");
    miso_fall_a: assert property ($changed(o_miso) && o_miso_oe && $past(o_miso_oe) |-> !i_sck)
        else $error("output changed outside low clock phase");
    standby_a: assert property ((i_cs_n && !o_write_busy) [*6] |-> !o_active)
        else $error("not in standby when idle");
    active_sel_a: assert property ($fell(i_cs_n) ##1 !i_cs_n [*5] |-> o_active)
        else $error("selection did not raise active");
    busy_len_a: assert property ($fell(o_write_busy) |-> cnt_q == P_WRITE_CYCLES)
        else $error("write cycle length wrong");
    no_arm_a: assert property (!seen_q |-> !o_miso_oe)
        else $error("output driven before first select fall");
    busy_start_a: assert property ($rose(o_write_busy) |-> i_cs_n && $past(i_cs_n, 3))
        else $error("write cycle started while selected");
    cover property ($rose(o_miso_oe));
    cover property ($rose(o_write_busy));
    cover property (!i_hold_n && !i_cs_n);
endmodule
`default_nettype wire

// *** test/ee_spi_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module ee_spi_master (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    output logic      o_hold_n,
    output logic      o_wp_n,
    input  wire logic i_miso
);
    logic [7:0] rx_q;   // last byte taken from the line
    logic       mode3;  // clock idles high
    event       got;    // a read byte is complete
    // power-up levels, write protect held steady
    initial begin
        o_sck    = 1'b0;
        o_cs_n   = 1'b0;
        o_mosi   = 1'b0;
        o_hold_n = 1'b1;
        o_wp_n   = 1'b1;
        mode3    = 1'b0;
        // select pulse inside reset: frame cleared, fall not seen
        #1;
        o_cs_n = 1'b1;
        #1;
        o_cs_n = 1'b0;
    end
    // write protect changed only between frames
    task automatic set_wp(input logic v);
        o_wp_n = v;
        #24;
    endtask
    // select in mode 0 or 3, clock parked first
    task automatic sel(input logic m3);
        mode3 = m3;
        o_sck = m3;
        #24;
        o_cs_n = 1'b0;
        #200;
    endtask
    // release the device, clock back to idle
    task automatic desel();
        if (!mode3) begin
            o_sck = 1'b0;
        end
        #24;
        o_cs_n = 1'b1;
        #100;
    endtask
    // n bits msb first, data set while clock low
    task automatic bits(input logic [7:0] tx, input int n, input logic rd);
        for (int i = 7; i > 7 - n; i--) begin
            o_sck  = 1'b0;
            o_mosi = tx[i];
            #24;
            o_sck   = 1'b1;
            rx_q[i] = i_miso;
            #24;
        end
        if (rd) begin
            -> got;
        end
    endtask
    // pause with junk traffic, optionally deselect inside it
    task automatic pause(input logic drop);
        o_sck = 1'b0;
        #24;
        o_hold_n = 1'b0;
        #24;
        repeat (2) begin
            o_sck  = 1'b1;
            o_mosi = ~o_mosi;
            #24;
            o_sck = 1'b0;
            #24;
        end
        if (drop) begin
            o_cs_n = 1'b1;
            #24;
        end
        o_hold_n = 1'b1;
        #124;
    endtask
endmodule
`default_nettype wire

// *** test/eeprom_spi_slave_front_end_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module eeprom_spi_slave_front_end_tb;
    import ee_pkg::*;
    localparam int P_WRITE_CYCLES = 80;
    logic       i_clk, i_rst;                          // system clock and reset
    logic       sck, cs_n, mosi, hold_n, wp_n, q_line; // link wires
    logic       o_miso, o_miso_oe, o_active, o_write_busy;
    logic [7:0] exp_q[$];                              // expected read bytes
    logic [7:0] d0, d1;                                // random write data
    int         fails = 0;
    int         cmp_count = 0;
    // released line shows a moving pattern
    assign q_line = o_miso_oe ? o_miso : i_clk;
    ee_spi_slave #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
        .o_active(o_active), .o_write_busy(o_write_busy));
    ee_spi_master m (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n),
        .o_wp_n(wp_n), .i_miso(q_line));
    // system clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // bounded wait on the write flag
    task automatic wait_busy(input logic want);
        int n;
        n = 0;
        while (o_write_busy !== want && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        check({7'h0, o_write_busy}, {7'h0, want});
        if (o_write_busy !== want) begin
            test_done();
        end
    endtask
    // status read, expectation noted first
    task automatic rd_stat(input logic [7:0] e);
        m.sel(1'b0);
        m.bits(OP_RDSR, 8, 1'b0);
        exp_q.push_back(e);
        m.bits(8'h00, 8, 1'b1);
        m.desel();
    endtask
    // status write after latch set, then the write cycle runs out
    task automatic wr_stat(input logic [7:0] v);
        m.sel(1'b0);
        m.bits(OP_WREN, 8, 1'b0);
        m.desel();
        m.sel(1'b0);
        m.bits(OP_WRSR, 8, 1'b0);
        m.bits(v, 8, 1'b0);
        m.desel();
        wait_busy(1'b1);
        wait_busy(1'b0);
    endtask
    // watcher of returned bytes
    initial begin
        forever begin
            @(m.got);
            check(m.rx_q, exp_q.pop_front());
        end
    end
    // hang guard
    initial begin
        #1500000;
        fails++;
        test_done();
    end
    // main sequence
    initial begin
        i_rst = 1'b1;
        void'($urandom(26594));
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_clk);
        // traffic before a select fall seen after reset is ignored
        m.bits(OP_RDSR, 8, 1'b0);
        m.bits(8'h00, 8, 1'b0);
        check({7'h0, o_miso_oe}, 8'h00);
        m.desel();
        d0 = 8'($urandom());
        d1 = 8'($urandom());
        // two bytes at the array top
        m.sel(1'b0);
        m.bits(OP_WREN, 8, 1'b0);
        m.desel();
        m.sel(1'b0);
        m.bits(OP_WRITE, 8, 1'b0);
        m.bits(8'h01, 8, 1'b0);
        m.bits(8'hff, 8, 1'b0);
        m.bits(8'hfe, 8, 1'b0);
        m.bits(d0, 8, 1'b0);
        m.bits(d1, 8, 1'b0);
        m.desel();
        wait_busy(1'b1);
        check({7'h0, o_active}, 8'h01);
        rd_stat(8'h01);
        wait_busy(1'b0);
        repeat (8) @(negedge i_clk);
        check({7'h0, o_active}, 8'h00);
        rd_stat(8'h00);
        // mode 3 read back with a pause between bytes
        m.sel(1'b1);
        m.bits(OP_READ, 8, 1'b0);
        m.bits(8'h01, 8, 1'b0);
        m.bits(8'hff, 8, 1'b0);
        m.bits(8'hfe, 8, 1'b0);
        exp_q.push_back(d0);
        m.bits(8'h00, 8, 1'b1);
        m.pause(1'b0);
        check({7'h0, o_miso_oe}, 8'h01);
        exp_q.push_back(d1);
        m.bits(8'h00, 8, 1'b1);
        m.desel();
        // partial command dropped by deselect in pause, latch kept
        m.sel(1'b0);
        m.bits(OP_WREN, 8, 1'b0);
        m.desel();
        m.sel(1'b0);
        m.bits(OP_RDSR, 4, 1'b0);
        m.pause(1'b1);
        rd_stat(8'h02);
        // protect size taken only while write protect is high
        d0 = {4'h0, 2'($urandom()), 2'h0};
        m.set_wp(1'b1);
        wr_stat(d0);
        rd_stat(d0);
        m.set_wp(1'b0);
        wr_stat(d0 ^ 8'h0c);
        rd_stat(d0);
        test_done();
    end
endmodule
bind ee_spi_slave ee_spi_mon #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) u_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
    .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .o_active(o_active), .o_write_busy(o_write_busy));
`default_nettype wire
